// *** src/fpsi_top.sv ***
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fpsi_top #(
  parameter int PPS_TIMEOUT_CYC = fpsi_pkg::PPS_TIMEOUT_CYC
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [fpsi_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [fpsi_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [fpsi_pkg::DATA_W-1:0]   rdata_o,
  output logic                               irq_o,
  input  wire logic                          link_valid_i,
  input  wire logic                          user_indicator_i,
  input  wire logic                          pps_i,
  input  wire logic [fpsi_pkg::NMON-1:0]     mon_alarm_i,
  input  wire logic                          sclk_detected_i,
  input  wire logic [fpsi_pkg::NCH-1:0]      adc_overload_i,
  input  wire logic [fpsi_pkg::NCH-1:0]      fifo_overrun_i,
  input  wire logic [fpsi_pkg::NTB-1:0]      loc_tmg_i,
  input  wire logic [fpsi_pkg::NTB-1:0]      tb_in_i,
  output logic      [fpsi_pkg::NTB-1:0]      tb_out_o,
  output logic      [fpsi_pkg::NTB-1:0]      tb_oe_o,
  output logic      [fpsi_pkg::NTB-1:0]      tmg_o,
  output logic                               link_up_indicator_o,
  output logic                               user_indicator_o,
  output logic                               timing_master_indicator_o,
  output logic                               pps_indicator_o,
  output logic                               over_temperature_indicator_o,
  output logic                               sample_clock_indicator_o,
  output logic      [fpsi_pkg::NCH-1:0]      channel_overload_indicator_o
);
  import fpsi_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] irq_en;
    logic [DATA_W-1:0] irq_st;
    logic [DATA_W-1:0] rdata;
    logic              link;
    logic              user;
    logic              master;
    logic              tmp;
    logic              sclk;
    logic              pps_v;
    logic [NCH-1:0]    ovl;
    logic [NTB-1:0]    tb_out;
    logic [NTB-1:0]    tb_oe;
    logic [NTB-1:0]    tmg;
    logic              irq;
  } fpsi_top_reg_t;

  fpsi_top_reg_t     q;
  fpsi_top_reg_t     d;
  logic              pps_valid;
  logic              pps_blink;
  logic              tmp_now;
  logic [NCH-1:0]    ovl_now;
  logic [DATA_W-1:0] events;
  logic              wr_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse-per-second validity and blink generation.
  fpsi_pps_mon #(
    .TIMEOUT_CYC (PPS_TIMEOUT_CYC)
  ) u_pps (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pps_i     (pps_i),
    .valid_o   (pps_valid),
    .blink_o   (pps_blink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition sources for the indicators.
  // any alarm lights
  assign tmp_now = |mon_alarm_i;
  assign ovl_now = ovl_pick(q.ctrl[CTRL_OVSEL +: NCH], adc_overload_i, fifo_overrun_i);

  // Events that set sticky interrupt bits, one cycle per occurrence.
  always_comb begin
    events                = ZERO_W;
    events[IRQ_PPS_LOST]  = q.pps_v & ~pps_valid;
    events[IRQ_TMP_ALARM] = tmp_now & ~q.tmp;
    events[IRQ_SCLK_LOST] = q.sclk & ~sclk_detected_i;
    events[IRQ_OVL]       = |(ovl_now & ~q.ovl);
  end

  assign wr_clr = wr_i && (addr_i == REG_IRQ_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, indicators and timing bus.
  always_comb begin
    d = q;
    d.link = link_valid_i;
    d.user = user_indicator_i;
    if (wr_i && (addr_i == REG_CTRL)) begin
      d.ctrl = wdata_i;
    end
    if (wr_i && (addr_i == REG_IRQ_EN)) begin
      d.irq_en = wdata_i;
    end
    d.master = q.ctrl[CTRL_MASTER];
    d.tmp = tmp_now;
    d.sclk = sclk_detected_i;
    d.pps_v = pps_valid;
    d.ovl = ovl_now;
    d.tb_oe  = {NTB{q.ctrl[CTRL_MASTER]}};
    d.tb_out = q.ctrl[CTRL_MASTER] ? loc_tmg_i : '0;
    d.tmg = q.ctrl[CTRL_MASTER] ? loc_tmg_i : tb_in_i;
    // A clear in the same cycle as an event leaves the bit set.
    d.irq_st = (q.irq_st & ~(wr_clr ? wdata_i : ZERO_W)) | events;
    d.irq    = |(d.irq_st & d.irq_en);
    // Read data stand only in the cycle after the strobe.
    d.rdata = ZERO_W;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL:     d.rdata = q.ctrl;
        REG_STATUS: begin
          d.rdata[ST_LINK]          = q.link;
          d.rdata[ST_PPS]           = q.pps_v;
          d.rdata[ST_TMP]           = q.tmp;
          d.rdata[ST_SCLK]          = q.sclk;
          d.rdata[ST_OVL +: NCH]    = q.ovl;
        end
        REG_IRQ_STAT: d.rdata = q.irq_st;
        REG_IRQ_EN:   d.rdata = q.irq_en;
        default:      d.rdata = ZERO_W;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.ctrl   <= CTRL_RST;
      q.irq_en <= IRQ_EN_RST;
      q.irq_st <= ZERO_W;
      q.rdata  <= ZERO_W;
      q.link   <= 1'b0;
      q.user   <= 1'b0;
      q.master <= 1'b0;
      q.tmp    <= 1'b0;
      q.sclk   <= 1'b0;
      q.pps_v  <= 1'b0;
      q.ovl    <= '0;
      q.tb_out <= '0;
      q.tb_oe  <= '0;
      q.tmg    <= '0;
      q.irq    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  assign rdata_o                      = q.rdata;
  assign irq_o                        = q.irq;
  assign link_up_indicator_o          = q.link;
  assign user_indicator_o             = q.user;
  assign timing_master_indicator_o    = q.master;
  assign pps_indicator_o              = pps_blink;
  assign over_temperature_indicator_o = q.tmp;
  assign sample_clock_indicator_o     = q.sclk;
  assign channel_overload_indicator_o = q.ovl;
  assign tb_out_o                     = q.tb_out;
  assign tb_oe_o                      = q.tb_oe;
  assign tmg_o                        = q.tmg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks of indicator, timing bus and interrupt behaviour.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ctrl_write;
    wr_i && (addr_i == REG_CTRL);
  endsequence

  sequence s_master_settled;
    timing_master_indicator_o && (tb_oe_o == {NTB{1'b1}});
  endsequence

  property p_link;
    ##1 link_up_indicator_o == $past(link_valid_i);
  endproperty
  a_link: assert property (p_link)
    else $error("link indicator does not follow link status");

  property p_user;
    ##1 user_indicator_o == $past(user_indicator_i);
  endproperty
  a_user: assert property (p_user)
    else $error("user indicator does not follow user logic");

  property p_master_on;
    s_ctrl_write ##0 wdata_i[CTRL_MASTER] |=> ##1 s_master_settled;
  endproperty
  a_master_on: assert property (p_master_on)
    else $error("master selection not shown two cycles after write");

  property p_tmp;
    (|mon_alarm_i) |=> over_temperature_indicator_o;
  endproperty
  a_tmp: assert property (p_tmp)
    else $error("alarm did not light over-temperature indicator");

  property p_sclk;
    !sclk_detected_i |=> !sample_clock_indicator_o;
  endproperty
  a_sclk: assert property (p_sclk)
    else $error("sample-clock indicator lit without clock");

  property p_ovl;
    ##1 channel_overload_indicator_o ==
        $past(ovl_pick(q.ctrl[CTRL_OVSEL +: NCH], adc_overload_i, fifo_overrun_i));
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overload indicator has wrong source");

  property p_tb_slave;
    !timing_master_indicator_o && !$past(q.ctrl[CTRL_MASTER]) && !q.ctrl[CTRL_MASTER]
      |=> (tb_oe_o == '0) && (tmg_o == $past(tb_in_i));
  endproperty
  a_tb_slave: assert property (p_tb_slave)
    else $error("slave drives the timing bus or ignores it");

  property p_tb_master;
    q.ctrl[CTRL_MASTER] |=> (tb_out_o == $past(loc_tmg_i)) && (tmg_o == $past(loc_tmg_i));
  endproperty
  a_tb_master: assert property (p_tb_master)
    else $error("master does not drive local timing");

  property p_sticky;
    events[IRQ_TMP_ALARM] && wr_clr && wdata_i[IRQ_TMP_ALARM] |=> q.irq_st[IRQ_TMP_ALARM];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event lost against a clear");

  property p_irq;
    (|(events & q.irq_en)) && !(wr_i && (addr_i == REG_IRQ_EN)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise the interrupt");

  // Sticky status: a clear drops only bits without a new event, else bits hold.
  property p_clr;
    wr_clr |=> (q.irq_st & $past(wdata_i & ~events)) == ZERO_W;
  endproperty
  a_clr: assert property (p_clr)
    else $error("write-one clear left a status bit set");

  property p_hold;
    !wr_clr |=> (q.irq_st & $past(q.irq_st)) == $past(q.irq_st);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status bit dropped without a clear");

  sequence s_status_read;
    rd_i && (addr_i == REG_STATUS);
  endsequence

  property p_rd_status;
    s_status_read |=> (rdata_o[ST_LINK] == $past(link_up_indicator_o)) &&
                      (rdata_o[ST_PPS] == $past(q.pps_v)) &&
                      (rdata_o[ST_TMP] == $past(over_temperature_indicator_o)) &&
                      (rdata_o[ST_SCLK] == $past(sample_clock_indicator_o)) &&
                      (rdata_o[ST_OVL +: NCH] == $past(channel_overload_indicator_o));
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read does not match the indicators");

  property p_master_off;
    !q.ctrl[CTRL_MASTER] |=> !timing_master_indicator_o && (tb_oe_o == '0) && (tb_out_o == '0);
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("slave shows master or drives the timing bus");

  property p_sclk_on;
    sclk_detected_i |=> sample_clock_indicator_o;
  endproperty
  a_sclk_on: assert property (p_sclk_on)
    else $error("sample-clock indicator dark with clock present");

  property p_tmp_off;
    !(|mon_alarm_i) |=> !over_temperature_indicator_o;
  endproperty
  a_tmp_off: assert property (p_tmp_off)
    else $error("over-temperature indicator lit without an alarm");

  property p_rd_idle;
    !rd_i |=> rdata_o == ZERO_W;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data shown without a read");

  property p_rd_once;
    rd_i ##1 !rd_i |=> rdata_o == ZERO_W;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data stayed past one cycle");

endmodule // fpsi_top

// *** src/fpsi_pkg.sv ***
// Functional notes
// - Link indicator follows the host link status.
// - User indicator driven only by application logic.
// - Master indicator lit while timing bus master.
// - Pulse indicator toggles on each valid pulse.
// - Any monitor alarm lights the over-temperature indicator.
// - Sample-clock indicator lit only while clock detected.
// - Per-channel select: converter overload or FIFO overrun.
// - Master drives timing bus, slave receives it.
package fpsi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the register port and the monitored groups.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NCH    = 4;
  localparam int NMON   = 4;
  localparam int NTB    = 3;

  // Timing bus pin positions within the three-pin groups.
  localparam int TB_CLK  = 0;
  localparam int TB_SYNC = 1;
  localparam int TB_GATE = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 4'h4;

  // Control field positions.
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_OVSEL  = 4;

  // Status field positions.
  localparam int ST_LINK = 0;
  localparam int ST_PPS  = 1;
  localparam int ST_TMP  = 2;
  localparam int ST_SCLK = 3;
  localparam int ST_OVL  = 4;

  // Interrupt event bit positions.
  localparam int IRQ_PPS_LOST  = 0;
  localparam int IRQ_TMP_ALARM = 1;
  localparam int IRQ_SCLK_LOST = 2;
  localparam int IRQ_OVL       = 3;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_W     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rate and the pulse-loss timeout.
  localparam int CLK_HZ         = 20_000_000;
  localparam int PPS_TIMEOUT_MS = 1200;
  localparam int PPS_TIMEOUT_CYC = (CLK_HZ / 1000) * PPS_TIMEOUT_MS;

  // Pulse monitor states.
  typedef enum logic [1:0] {
    FPSI_PPS_LOST  = 2'b01,
    FPSI_PPS_VALID = 2'b10
  } fpsi_pps_st_t;

  // Picks the overload source per channel: 0 converter flag, 1 FIFO overrun.
  function automatic logic [NCH-1:0] ovl_pick(input logic [NCH-1:0] sel,
                                              input logic [NCH-1:0] adc,
                                              input logic [NCH-1:0] fifo);
    ovl_pick = (adc & ~sel) | (fifo & sel);
  endfunction

endpackage

// *** src/fpsi_pps_mon.sv ***
`timescale 1ns/1ps
module fpsi_pps_mon #(
  parameter int TIMEOUT_CYC = fpsi_pkg::PPS_TIMEOUT_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pps_i,
  output logic      valid_o,
  output logic      blink_o
);
  import fpsi_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  typedef struct packed {
    fpsi_pps_st_t     st;
    logic             prev;
    logic             blink;
    logic [CNT_W-1:0] cnt;
  } fpsi_pps_reg_t;

  fpsi_pps_reg_t q;
  fpsi_pps_reg_t d;
  logic          rise;

  ////////////////////////////////////////////////////////////////////////////
  // A pulse restarts the silence counter and toggles the indicator.
  assign rise = pps_i & ~q.prev;

  always_comb begin
    d      = q;
    d.prev = pps_i;
    unique case (q.st)
      FPSI_PPS_LOST: begin
        if (rise) begin
          d.st    = FPSI_PPS_VALID;
          d.blink = 1'b1;
          d.cnt   = '0;
        end
      end
      FPSI_PPS_VALID: begin
        if (rise) begin
          d.blink = ~q.blink;
          d.cnt   = '0;
        end else if (q.cnt == CNT_LAST) begin
          d.st    = FPSI_PPS_LOST;
          d.blink = 1'b0;
        end else begin
          d.cnt = q.cnt + CNT_ONE;
        end
      end
      default: begin
        d.st    = FPSI_PPS_LOST;
        d.blink = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.st    <= FPSI_PPS_LOST;
      q.prev  <= 1'b0;
      q.blink <= 1'b0;
      q.cnt   <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid_o = (q.st == FPSI_PPS_VALID);
  assign blink_o = q.blink;

  ////////////////////////////////////////////////////////////////////////////
  // Checks of the pulse monitor.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_lost_pulse;
    !valid_o ##0 rise;
  endsequence

  sequence s_lit;
    valid_o && blink_o;
  endsequence

  property p_first_lit;
    s_lost_pulse |=> s_lit;
  endproperty
  a_first_lit: assert property (p_first_lit)
    else $error("first pulse did not light the indicator");

  property p_toggle;
    valid_o && rise |=> valid_o && (blink_o != $past(blink_o));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pulse indicator did not toggle");

  property p_timeout;
    valid_o && !rise && (q.cnt == CNT_LAST) |=> !valid_o && !blink_o;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("pulse loss not flagged at timeout");

  property p_dark_lost;
    !valid_o |-> !blink_o;
  endproperty
  a_dark_lost: assert property (p_dark_lost)
    else $error("indicator lit without a valid pulse");

endmodule // fpsi_pps_mon

// *** tb/fpsi_tb_peer.sv ***
`timescale 1ns/1ps
module fpsi_tb_peer (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    peer_master_i,
  input  wire logic [fpsi_pkg::NTB-1:0] tb_out_i,
  input  wire logic [fpsi_pkg::NTB-1:0] tb_oe_i,
  output logic      [fpsi_pkg::NTB-1:0] pins_o
);
  import fpsi_pkg::*;

  logic [NTB-1:0] pat_q;

  ////////////////////////////////////////////////////////////////////////////
  // A peer master runs its own timing, so its pattern moves every cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pat_q <= 3'h0;
    else
      pat_q <= pat_q + 3'h3;
  end

  // peer drives its pattern as master, the inverted pattern otherwise
  // The board wins where it drives; an undriven pin follows the moving peer pattern, so an undriven bus changes value every cycle.
  always_comb begin
    for (int i = 0; i < NTB; i++) begin
      pins_o[i] = tb_oe_i[i] ? tb_out_i[i] : (peer_master_i ? pat_q[i] : ~pat_q[i]);
    end
  end
endmodule // fpsi_tb_peer

// *** tb/fpsi_top_tb.sv ***
`timescale 1ns/1ps
module fpsi_top_tb;
  import fpsi_pkg::*;

  localparam int TMO = 50;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i   = 1'b0;
  logic [ADDR_W-1:0] addr_i    = 4'h0;
  logic [DATA_W-1:0] wdata_i   = 8'h00;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic              link_i    = 1'b0;
  logic              user_i    = 1'b0;
  logic              pps_i     = 1'b0;
  logic [NMON-1:0]   mon_i     = 4'h0;
  logic              sclk_i    = 1'b0;
  logic [NCH-1:0]    adc_i     = 4'h0;
  logic [NCH-1:0]    fifo_i    = 4'h0;
  logic [NTB-1:0]    loc_i     = 3'h5;
  logic              peer_m    = 1'b1;
  logic [DATA_W-1:0] rdata_o;
  logic              irq_o;
  logic [NTB-1:0]    tb_out_o, tb_oe_o, tmg_o, pins, prev_w;
  logic              link_o, user_o, mast_o, pps_o, tmp_o, sclk_o;
  logic [NCH-1:0]    ovl_o;
  logic [DATA_W-1:0] v;
  int                fail_count = 0;
  int                compares   = 0;
  int                cyc        = 0;

  fpsi_top #(.PPS_TIMEOUT_CYC(TMO)) fpsi_top_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .link_valid_i(link_i), .user_indicator_i(user_i), .pps_i(pps_i),
    .mon_alarm_i(mon_i), .sclk_detected_i(sclk_i), .adc_overload_i(adc_i),
    .fifo_overrun_i(fifo_i), .loc_tmg_i(loc_i), .tb_in_i(pins), .tb_out_o(tb_out_o),
    .tb_oe_o(tb_oe_o), .tmg_o(tmg_o), .link_up_indicator_o(link_o),
    .user_indicator_o(user_o), .timing_master_indicator_o(mast_o),
    .pps_indicator_o(pps_o), .over_temperature_indicator_o(tmp_o),
    .sample_clock_indicator_o(sclk_o), .channel_overload_indicator_o(ovl_o));

  fpsi_tb_peer fpsi_tb_peer_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .peer_master_i(peer_m), .tb_out_i(tb_out_o), .tb_oe_i(tb_oe_o), .pins_o(pins));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, wire history and the hang guard.
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    prev_w <= pins;
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison, wait and bus cycle tasks.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    wait_cyc(1);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    wait_cyc(1);
    rd_i <= 1'b0;
    d = rdata_o;
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, read-only and unmapped places.
  task automatic t_regs();
    reg_rd(REG_CTRL, v);
    chk("ctrl reset", CTRL_RST, v);
    reg_rd(REG_IRQ_EN, v);
    chk("irq_en reset", IRQ_EN_RST, v);
    wait_cyc(1);
    chk("rdata idle", 8'h00, rdata_o);
    reg_wr(REG_IRQ_EN, 8'h0F);
    reg_rd(REG_IRQ_EN, v);
    chk("irq_en rw", 8'h0F, v);
    reg_wr(REG_IRQ_EN, 8'h00);
    reg_wr(REG_STATUS, 8'hFF);
    reg_rd(REG_STATUS, v);
    chk("status ro", 8'h00, v);
    reg_rd(4'hF, v);
    chk("unmapped", 8'h00, v);
    reg_rd(REG_IRQ_CLR, v);
    chk("irq_clr read", 8'h00, v);
  endtask

  // Level indicators and masked sticky events.
  task automatic t_indic();
    @(posedge sys_clk_i);
    {link_i, user_i, sclk_i} <= 3'h7;
    wait_cyc(1);
    chk("link led", 8'h01, 8'(link_o));
    chk("user led", 8'h01, 8'(user_o));
    chk("sclk led", 8'h01, 8'(sclk_o));
    reg_rd(REG_STATUS, v);
    chk("status", 8'h09, v);
    {link_i, user_i, sclk_i} <= 3'h0;
    wait_cyc(1);
    chk("link led off", 8'h00, 8'(link_o));
    chk("user led off", 8'h00, 8'(user_o));
    chk("sclk led off", 8'h00, 8'(sclk_o));
    for (int i = 0; i < NMON; i++) begin
      mon_i <= 4'(1 << i);
      wait_cyc(1);
      chk("tmp led", 8'h01, 8'(tmp_o));
      mon_i <= 4'h0;
      wait_cyc(1);
      chk("tmp led off", 8'h00, 8'(tmp_o));
    end
    reg_rd(REG_IRQ_STAT, v);
    chk("irq_stat", 8'h06, v);
    chk("irq masked", 8'h00, 8'(irq_o));
    reg_wr(REG_IRQ_CLR, 8'h06);
    reg_rd(REG_IRQ_STAT, v);
    chk("irq_stat clr", 8'h00, v);
    // An alarm rising in the cycle of its clear stays recorded.
    @(posedge sys_clk_i);
    mon_i   <= 4'h1;
    addr_i  <= REG_IRQ_CLR;
    wdata_i <= 8'h02;
    wr_i    <= 1'b1;
    wait_cyc(1);
    wr_i  <= 1'b0;
    mon_i <= 4'h0;
    reg_rd(REG_IRQ_STAT, v);
    chk("irq_stat race", 8'h02, v);
    reg_wr(REG_IRQ_CLR, 8'h02);
  endtask

  // Timing bus direction in slave and master configuration.
  task automatic t_master();
    wait_cyc(1);
    for (int k = 0; k < 4; k++) begin
      chk("slave tmg", 8'(prev_w), 8'(tmg_o));
      wait_cyc(1);
    end
    chk("slave oe", 8'h00, 8'(tb_oe_o));
    chk("slave out", 8'h00, 8'(tb_out_o));
    chk("slave led", 8'h00, 8'(mast_o));
    peer_m <= 1'b0;
    reg_wr(REG_CTRL, 8'h01);
    wait_cyc(1);
    chk("master led", 8'h01, 8'(mast_o));
    chk("master oe", 8'h07, 8'(tb_oe_o));
    chk("master out", 8'h05, 8'(tb_out_o));
    loc_i <= 3'h2;
    wait_cyc(1);
    chk("master out", 8'h02, 8'(tb_out_o));
    chk("master tmg", 8'h02, 8'(tmg_o));
    chk("bus pins", 8'h02, 8'(pins));
    reg_wr(REG_CTRL, 8'h00);
    wait_cyc(1);
    chk("back to slave", 8'h00, 8'({mast_o, tb_oe_o}));
    peer_m <= 1'b1;
  endtask

  // Per-channel overload source select.
  task automatic t_ovl();
    adc_i <= 4'h9;
    fifo_i <= 4'h6;
    reg_wr(REG_CTRL, 8'hA0);
    wait_cyc(1);
    chk("ovl sel A", 8'h03, 8'(ovl_o));
    reg_wr(REG_CTRL, 8'h50);
    wait_cyc(1);
    chk("ovl sel 5", 8'h0C, 8'(ovl_o));
    reg_rd(REG_STATUS, v);
    chk("status ovl", 8'hC0, v);
    reg_rd(REG_IRQ_STAT, v);
    chk("irq_stat ovl", 8'h08, v);
    adc_i <= 4'h0;
    fifo_i <= 4'h0;
  endtask

  // Pulse blinking, loss timeout and the interrupt path.
  task automatic t_pps();
    reg_wr(REG_IRQ_CLR, 8'h0F);
    for (int k = 0; k < 3; k++) begin
      pps_i <= 1'b1;
      wait_cyc(1);
      pps_i <= 1'b0;
      chk("pps led", (k % 2 == 0) ? 8'h01 : 8'h00, 8'(pps_o));
      wait_cyc(8);
    end
    reg_rd(REG_STATUS, v);
    chk("pps valid", 8'h02, v);
    wait_cyc(TMO + 10);
    chk("pps lost led", 8'h00, 8'(pps_o));
    reg_rd(REG_IRQ_STAT, v);
    chk("pps lost irq", 8'h01, v);
    chk("irq masked", 8'h00, 8'(irq_o));
    reg_wr(REG_IRQ_EN, 8'h01);
    wait_cyc(1);
    chk("irq on", 8'h01, 8'(irq_o));
    reg_wr(REG_IRQ_CLR, 8'h01);
    wait_cyc(1);
    chk("irq cleared", 8'h00, 8'(irq_o));
    reg_wr(REG_IRQ_EN, 8'h02);
    mon_i <= 4'h1;
    wait_cyc(1);
    chk("irq event", 8'h01, 8'(irq_o));
    mon_i <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_indic();
    t_master();
    t_ovl();
    t_pps();
    tally_and_finish();
  end
endmodule // fpsi_top_tb
